// ==== rtl/pfc_params.svh ====
// Purpose: constants for the parallel flash command controller
// Assumes: 100 MHz reference clock, byte-wide flash with 19 address bits
// Notes:   offsets, command bytes, field bit positions and timing counts only
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// ****************************************************************
// unlock and command codes
// ****************************************************************
`define PFC_UNLOCK_ADDR1   19'h05555
`define PFC_UNLOCK_ADDR2   19'h02AAA
`define PFC_UNLOCK_DATA1   8'hAA
`define PFC_UNLOCK_DATA2   8'h55
`define PFC_CMD_RESET      8'hF0
`define PFC_CMD_IDENT      8'h90
`define PFC_CMD_PROGRAM    8'hA0
`define PFC_CMD_ERASE_SET  8'h80
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_SECT_ERASE 8'h30
`define PFC_CMD_SUSPEND    8'hB0
`define PFC_CMD_RESUME     8'h30

// ****************************************************************
// identification offsets and fields
// ****************************************************************
`define PFC_ID_MFR_ADDR    19'h00000
`define PFC_ID_PART_ADDR   19'h00001
`define PFC_ID_PROT_ADDR   19'h00002
`define PFC_SECT_LSB       16
`define PFC_PROT_BIT       0
`define PFC_PARITY_BIT     7

// ****************************************************************
// bus cycle timing
// ****************************************************************
`define PFC_CLK_NS         10
`define PFC_SETUP_NS       40
`define PFC_PULSE_NS       50
`define PFC_HOLD_NS        20
`define PFC_ACCESS_NS      150
`define PFC_SETUP_CYC      ((`PFC_SETUP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_PULSE_CYC      ((`PFC_PULSE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_HOLD_CYC       ((`PFC_HOLD_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_ACCESS_CYC     ((`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)

`endif

// ==== rtl/pfc_pkg.sv ====
// Purpose: types shared by the flash command controller
// Assumes: pfc_params.svh holds the numbers
// Notes:   operations requested by the user side
`default_nettype none
package pfc_pkg;
  // ****************************************************************
  // user operations
  // ****************************************************************
  typedef enum logic [3:0] {
    PFC_OP_READ    = 4'h0,  // plain array read
    PFC_OP_RESET1  = 4'h1,  // one-cycle reset
    PFC_OP_RESET4  = 4'h2,  // unlocked reset
    PFC_OP_IDENT   = 4'h3,  // enter identification mode
    PFC_OP_PROGRAM = 4'h4,  // byte program
    PFC_OP_CHIP_ER = 4'h5,  // chip erase
    PFC_OP_SECT_ER = 4'h6,  // sector erase
    PFC_OP_SUSPEND = 4'h7,  // erase suspend
    PFC_OP_RESUME  = 4'h8,  // erase resume
    PFC_OP_ID_READ = 4'h9,  // read mfr / part / protection byte
    PFC_OP_HV_READ = 4'hA   // identification read with raised pin
  } pfc_op_t;

  // one request from the user side
  typedef struct packed {
    pfc_op_t     op;    // what to do
    logic [18:0] addr;  // array, sector or id location
    logic [7:0]  data;  // program value
  } pfc_req_t;

  // one bus cycle handed to the cycle engine
  typedef struct packed {
    logic        write;  // 1 write, 0 read
    logic        hv;     // raise the identification pin
    logic [18:0] addr;
    logic [7:0]  data;
  } pfc_cyc_t;
endpackage
`default_nettype wire

// ==== rtl/pfc_cycle.sv ====
// Purpose: one flash bus cycle, read or write, on the pins
// Assumes: caller holds cyc_i stable while busy
// Notes:   write strobes with chip enable low and output gate high
`include "pfc_params.svh"
`default_nettype none
module pfc_cycle
  import pfc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,   // one-cycle start
  input  wire pfc_cyc_t    cyc_i,
  input  wire logic [7:0]  dq_sync_i, // pin data after synchroniser
  output logic             done_o,    // one-cycle completion
  output logic [7:0]       rdata_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [18:0]      addr_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  output logic             hv_o
);
  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  typedef enum logic [4:0] {
    PFC_C_IDLE  = 5'h01,  // pins parked
    PFC_C_SETUP = 5'h02,  // address, chip enable out
    PFC_C_PULSE = 5'h04,  // write strobe or output gate low
    PFC_C_HOLD  = 5'h08,  // strobe high, data held
    PFC_C_DONE  = 5'h10   // report
  } pfc_cst_t;

  pfc_cst_t    st, next_st;        // state
  logic [7:0]  cnt, next_cnt;      // phase counter
  logic [7:0]  rdata, next_rdata;  // captured read byte
  logic        wr, next_wr;        // latched direction

  // next state and pin values
  always_comb begin
    next_st    = st;
    next_cnt   = cnt;
    next_rdata = rdata;
    next_wr    = wr;
    case (st)
      PFC_C_IDLE: begin
        if (start_i) begin
          next_wr  = cyc_i.write;
          next_cnt = 8'(`PFC_SETUP_CYC);
          next_st  = PFC_C_SETUP;
        end
      end
      PFC_C_SETUP: begin
        if (cnt <= 8'h01) begin
          next_cnt = wr ? 8'(`PFC_PULSE_CYC) : 8'(`PFC_ACCESS_CYC);
          next_st  = PFC_C_PULSE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PFC_C_PULSE: begin
        if (cnt <= 8'h01) begin
          if (!wr) begin
            next_rdata = dq_sync_i;  // sample before the gate rises
          end
          next_cnt = 8'(`PFC_HOLD_CYC);
          next_st  = PFC_C_HOLD;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PFC_C_HOLD: begin
        if (cnt <= 8'h01) begin
          next_st = PFC_C_DONE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PFC_C_DONE: begin
        next_st = PFC_C_IDLE;
      end
      default: begin
        next_st = PFC_C_IDLE;
      end
    endcase
  end

  // register state; pins derive from next state so they are flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= PFC_C_IDLE;
      cnt     <= 8'h00;
      rdata   <= 8'h00;
      wr      <= 1'b0;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      addr_o  <= 19'h00000;
      dq_o    <= 8'h00;
      dq_oe_o <= 1'b0;
      hv_o    <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      st      <= next_st;
      cnt     <= next_cnt;
      rdata   <= next_rdata;
      wr      <= next_wr;
      ce_n_o  <= (next_st == PFC_C_IDLE) || (next_st == PFC_C_DONE);
      // output gate low only on reads, high through every write
      oe_n_o  <= !((next_st == PFC_C_PULSE) && !next_wr);
      we_n_o  <= !((next_st == PFC_C_PULSE) && next_wr);
      if (start_i && (st == PFC_C_IDLE)) begin
        addr_o <= cyc_i.addr;
        dq_o   <= cyc_i.data;
        hv_o   <= cyc_i.hv;
      end
      // drive data only for writes, released before any read gate
      dq_oe_o <= next_wr && (next_st != PFC_C_IDLE) && (next_st != PFC_C_DONE);
      if (next_st == PFC_C_IDLE) begin
        hv_o <= 1'b0;
      end
      done_o  <= (next_st == PFC_C_DONE);
    end
  end

  assign rdata_o = rdata;
endmodule
`default_nettype wire

// ==== rtl/pfc_ctrl.sv ====
// Purpose: host controller driving a byte-wide parallel flash by its pins
// Assumes: device keeps its own rules; one request at a time
// Notes:   builds unlock sequences, reads ids and protection state
//
// Operation
// - raised pin nine: only bits 0,1,6 matter; the code also keeps sector bits 18..16
// - write: write enable, chip enable low, gate high
// - unlock pair then command at 5555h
// - single F0h anywhere resets to read
// - host leaves id mode by reset; the code also clears its id mode flag after program and chip erase
`include "pfc_params.svh"
`default_nettype none
module pfc_ctrl
  import pfc_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        REQ_VALID_I,  // request strobe
  input  wire pfc_req_t    REQ_I,
  output logic             REQ_READY_O,  // idle, may take a request
  output logic             RSP_VALID_O,  // one-cycle completion
  output logic [7:0]       RSP_DATA_O,   // read byte
  output logic             RSP_PARITY_OK_O, // id byte has odd parity
  output logic             RSP_ERR_O,    // refused request
  output logic             ID_MODE_O,    // device left in id mode
  output logic             ERASING_O,    // sector erase in progress
  output logic             FLASH_CE_N_O,
  output logic             FLASH_OE_N_O,
  output logic             FLASH_WE_N_O,
  output logic [18:0]      FLASH_ADDR_O,
  output logic [7:0]       FLASH_DQ_O,
  output logic             FLASH_DQ_OE_O,
  input  wire logic [7:0]  FLASH_DQ_I,
  output logic             FLASH_HV_O    // raise id_voltage_address_pin
);
  // ****************************************************************
  // pin input synchroniser
  // ****************************************************************
  logic [7:0] dq_meta, dq_sync;  // two-stage sampling of data pins

  always_ff @(posedge REF_CLK_I) begin
    dq_meta <= FLASH_DQ_I;
    dq_sync <= dq_meta;
  end

  // ****************************************************************
  // sequence state
  // ****************************************************************
  typedef enum logic [3:0] {
    PFC_S_IDLE = 4'h1,  // waiting for a request
    PFC_S_ISSUE = 4'h2, // start a bus cycle
    PFC_S_WAIT = 4'h4,  // cycle in flight
    PFC_S_RESP = 4'h8   // report to user
  } pfc_st_t;

  pfc_st_t     st, next_st;
  pfc_req_t    req, next_req;      // latched request
  logic [2:0]  idx, next_idx;      // cycle index in sequence
  logic [2:0]  len, next_len;      // cycles in sequence
  logic        idm, next_idm;      // device is in id mode
  logic        ers, next_ers;      // sector erase running / suspended
  logic        err, next_err;
  logic        start;
  pfc_cyc_t    cyc;
  logic        cdone;
  logic [7:0]  rdata;

  // number of bus cycles per operation
  function automatic logic [2:0] op_len(input pfc_op_t op);
    case (op)
      // reset and ident end on their command write, the third cycle; no fourth cycle follows
      PFC_OP_RESET4, PFC_OP_IDENT:                 op_len = 3'd3;
      PFC_OP_PROGRAM:                              op_len = 3'd4;
      PFC_OP_CHIP_ER, PFC_OP_SECT_ER:              op_len = 3'd6;
      default:                                     op_len = 3'd1;
    endcase
  endfunction

  // bus cycle number i of the latched request
  always_comb begin
    cyc       = '0;
    cyc.write = 1'b1;
    case (idx)
      3'd0, 3'd3: begin
        cyc.addr = `PFC_UNLOCK_ADDR1;
        cyc.data = `PFC_UNLOCK_DATA1;
      end
      3'd1, 3'd4: begin
        cyc.addr = `PFC_UNLOCK_ADDR2;
        cyc.data = `PFC_UNLOCK_DATA2;
      end
      3'd2: begin
        cyc.addr = `PFC_UNLOCK_ADDR1;
        case (req.op)
          PFC_OP_RESET4:  cyc.data = `PFC_CMD_RESET;
          PFC_OP_IDENT:   cyc.data = `PFC_CMD_IDENT;
          PFC_OP_PROGRAM: cyc.data = `PFC_CMD_PROGRAM;
          default:        cyc.data = `PFC_CMD_ERASE_SET;
        endcase
      end
      default: begin
        cyc.addr = req.addr;
        cyc.data = req.data;
      end
    endcase
    // last cycle of the longer sequences
    if (idx == 3'd3 && req.op == PFC_OP_PROGRAM) begin
      cyc.addr = req.addr;
      cyc.data = req.data;
    end
    if (idx == 3'd5) begin
      cyc.addr = (req.op == PFC_OP_CHIP_ER) ? `PFC_UNLOCK_ADDR1 : req.addr;
      cyc.data = (req.op == PFC_OP_CHIP_ER) ? `PFC_CMD_CHIP_ERASE : `PFC_CMD_SECT_ERASE;
    end
    // single-cycle operations
    if (len == 3'd1) begin
      // reads need the user's location; single writes ignore it
      cyc.addr = req.addr;
      case (req.op)
        PFC_OP_RESET1:  cyc.data = `PFC_CMD_RESET;
        PFC_OP_SUSPEND: cyc.data = `PFC_CMD_SUSPEND;
        PFC_OP_RESUME:  cyc.data = `PFC_CMD_RESUME;
        PFC_OP_ID_READ: cyc.write = 1'b0;
        PFC_OP_HV_READ: begin
          cyc.write = 1'b0;
          cyc.hv    = 1'b1;
          // bits 0, 1 and 6 pick the byte, bits 18..16 the sector
          cyc.addr  = req.addr & 19'h70043;
        end
        default:        cyc.write = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // request sequencer
  // ****************************************************************
  always_comb begin
    next_st  = st;
    next_req = req;
    next_idx = idx;
    next_len = len;
    next_idm = idm;
    next_ers = ers;
    next_err = err;
    start    = 1'b0;
    case (st)
      PFC_S_IDLE: begin
        if (REQ_VALID_I) begin
          next_req = REQ_I;
          next_idx = 3'd0;
          next_len = op_len(REQ_I.op);
          next_err = 1'b0;
          // suspend and resume only while a sector erase is on
          if ((REQ_I.op == PFC_OP_SUSPEND || REQ_I.op == PFC_OP_RESUME) && !ers) begin
            next_err = 1'b1;
            next_st  = PFC_S_RESP;
          end else if (REQ_I.op == PFC_OP_ID_READ && !idm) begin
            next_err = 1'b1;
            next_st  = PFC_S_RESP;
          end else begin
            next_st = PFC_S_ISSUE;
          end
        end
      end
      PFC_S_ISSUE: begin
        start   = 1'b1;
        next_st = PFC_S_WAIT;
      end
      PFC_S_WAIT: begin
        if (cdone) begin
          if (idx + 3'd1 >= len) begin
            next_st = PFC_S_RESP;
            // track what the device mode now is
            case (req.op)
              PFC_OP_IDENT:   next_idm = 1'b1;
              PFC_OP_RESET1, PFC_OP_RESET4: begin
                next_idm = 1'b0;
                next_ers = 1'b0;
              end
              PFC_OP_SECT_ER: next_ers = 1'b1;
              PFC_OP_PROGRAM, PFC_OP_CHIP_ER: next_idm = 1'b0;
              default:        next_idm = idm;
            endcase
          end else begin
            next_idx = idx + 3'd1;
            next_st  = PFC_S_ISSUE;
          end
        end
      end
      PFC_S_RESP: begin
        next_st = PFC_S_IDLE;
      end
      default: begin
        next_st = PFC_S_IDLE;
      end
    endcase
  end

  // registered state and user-side outputs
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      st              <= PFC_S_IDLE;
      req             <= '0;
      idx             <= 3'd0;
      len             <= 3'd1;
      idm             <= 1'b0;
      ers             <= 1'b0;
      err             <= 1'b0;
      REQ_READY_O     <= 1'b0;
      RSP_VALID_O     <= 1'b0;
      RSP_DATA_O      <= 8'h00;
      RSP_PARITY_OK_O <= 1'b0;
      RSP_ERR_O       <= 1'b0;
      ID_MODE_O       <= 1'b0;
      ERASING_O       <= 1'b0;
    end else begin
      st              <= next_st;
      req             <= next_req;
      idx             <= next_idx;
      len             <= next_len;
      idm             <= next_idm;
      ers             <= next_ers;
      err             <= next_err;
      REQ_READY_O     <= (next_st == PFC_S_IDLE);
      RSP_VALID_O     <= (next_st == PFC_S_RESP);
      if (next_st == PFC_S_RESP) begin
        RSP_DATA_O      <= next_err ? 8'h00 : rdata;
        RSP_PARITY_OK_O <= ^rdata;
        RSP_ERR_O       <= next_err;
      end
      ID_MODE_O       <= next_idm;
      ERASING_O       <= next_ers;
    end
  end

  // ****************************************************************
  // bus cycle engine
  // ****************************************************************
  pfc_cycle u_cycle (
    .clk_i     (REF_CLK_I),
    .rst_i     (RST_I),
    .start_i   (start),
    .cyc_i     (cyc),
    .dq_sync_i (dq_sync),
    .done_o    (cdone),
    .rdata_o   (rdata),
    .ce_n_o    (FLASH_CE_N_O),
    .oe_n_o    (FLASH_OE_N_O),
    .we_n_o    (FLASH_WE_N_O),
    .addr_o    (FLASH_ADDR_O),
    .dq_o      (FLASH_DQ_O),
    .dq_oe_o   (FLASH_DQ_OE_O),
    .hv_o      (FLASH_HV_O)
  );
  // refusal by protected sectors is seen by a protection read
endmodule
`default_nettype wire

// ==== bench/pfc_ctrl_monitor.sv ====
// Purpose: pin protocol checks for the flash command controller
// Assumes: one clock domain, synchronous reset
// Notes:   bound into pfc_ctrl after the module
`default_nettype none
module pfc_ctrl_monitor (
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        FLASH_CE_N_O,
  input wire logic        FLASH_OE_N_O,
  input wire logic        FLASH_WE_N_O,
  input wire logic [18:0] FLASH_ADDR_O,
  input wire logic [7:0]  FLASH_DQ_O,
  input wire logic        FLASH_DQ_OE_O,
  input wire logic        FLASH_HV_O
);
  // ****************************************************************
  // pin protocol
  // ****************************************************************
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  we_strobe_a: assert property (!FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_OE_N_O)
    else $error("write strobe without select or with gate low");
  ce_idle_a: assert property (FLASH_CE_N_O |-> FLASH_WE_N_O && FLASH_OE_N_O)
    else $error("strobe while deselected");
  we_fall_a: assert property ($fell(FLASH_WE_N_O) |-> FLASH_DQ_OE_O && !$past(FLASH_CE_N_O))
    else $error("write strobe fell before select or data");
  we_pulse_a: assert property ($fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O [*5] ##1 FLASH_WE_N_O)
    else $error("write strobe width wrong");
  hold_pins_a: assert property (!FLASH_WE_N_O && !$past(FLASH_WE_N_O) |-> $stable(FLASH_ADDR_O) && $stable(FLASH_DQ_O))
    else $error("address or data moved in write strobe");
  we_rise_a: assert property ($rose(FLASH_WE_N_O) |-> !FLASH_CE_N_O && FLASH_DQ_OE_O)
    else $error("data released before strobe rose");
  no_fight_a: assert property (!FLASH_OE_N_O |-> !FLASH_DQ_OE_O)
    else $error("host drives data while gate low");
  hv_mask_a: assert property (FLASH_HV_O |-> (FLASH_ADDR_O & 19'h0FFBC) == 19'h00000 && FLASH_WE_N_O)
    else $error("raised pin with stray address bits or write");
endmodule

bind pfc_ctrl pfc_ctrl_monitor mon_u (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .FLASH_CE_N_O(FLASH_CE_N_O),
  .FLASH_OE_N_O(FLASH_OE_N_O), .FLASH_WE_N_O(FLASH_WE_N_O), .FLASH_ADDR_O(FLASH_ADDR_O),
  .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE_O(FLASH_DQ_OE_O), .FLASH_HV_O(FLASH_HV_O));
`default_nettype wire

// ==== bench/pfc_flash_model.sv ====
// Purpose: behavioural byte-wide flash answering the controller
// Assumes: program and erase finish at once
// Notes:   floating bus shows the inverse of its last value
`default_nettype none
module pfc_flash_model #(
  parameter logic [7:0] MFR_CODE  = 8'h07,  // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h8C,  // arbitrary value
  parameter logic [7:0] PROT_MASK = 8'h80   // bit per sector, 1 protected
) (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        dq_oe_i,
  input  wire logic        hv_i,
  output logic [7:0]       bus_o
);
  // ****************************************************************
  // array and command state
  // ****************************************************************
  logic [7:0]  mem [int];    // absent byte reads erased
  logic [18:0] lat_a;        // address from write strobe fall
  logic [7:0]  rd;           // byte the device offers
  logic [7:0]  last = 8'h00; // last level on the bus
  logic        drive;        // device outputs on
  logic        idm = 1'b0;   // identification mode
  logic        ers = 1'b0;   // sector erase running
  int          step = 0;     // command cycle counter

  function automatic logic [7:0] arr(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction

  function automatic logic [7:0] id_byte(input logic [18:0] a);
    case ({a[6], a[1], a[0]})
      3'b000:  return MFR_CODE;
      3'b001:  return PART_CODE;
      3'b010:  return {7'h00, PROT_MASK[a[18:16]]};
      default: return 8'h00;
    endcase
  endfunction

  task erase_set(input logic [7:0] sel);
    foreach (mem[k]) begin
      if (sel[k[18:16]] && !PROT_MASK[k[18:16]]) mem[k] = 8'hFF;
    end
  endtask

  task write_cmd(input logic [18:0] a, input logic [7:0] d);
    logic [14:0] c;
    c = a[14:0];
    if (step == 3) begin
      if (!PROT_MASK[a[18:16]]) mem[int'(a)] = arr(a) & d;
      step = 0;
    end else if (d == 8'hF0) begin
      step = 0;
      idm = 1'b0;
      ers = 1'b0;
    end else if (ers && step == 0 && (d == 8'hB0 || d == 8'h30)) begin
      step = 0;
    end else begin
      case (step)
        0: step = (c == 15'h5555 && d == 8'hAA) ? 1 : 0;
        1: step = (c == 15'h2AAA && d == 8'h55) ? 2 : 0;
        2: begin
          idm = idm | (c == 15'h5555 && d == 8'h90);
          step = (c != 15'h5555) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
        end
        4: step = (c == 15'h5555 && d == 8'hAA) ? 5 : 0;
        5: step = (c == 15'h2AAA && d == 8'h55) ? 6 : 0;
        default: begin
          if (c == 15'h5555 && d == 8'h10) erase_set(8'hFF);
          if (d == 8'h30) erase_set(8'h01 << a[18:16]);
          ers = (d == 8'h30);
          step = 0;
        end
      endcase
    end
  endtask

  // address latched on the later fall, data on the earlier rise
  always @(negedge we_n_i) if (!ce_n_i) lat_a = addr_i;
  always @(posedge we_n_i) if (!ce_n_i && oe_n_i) write_cmd(lat_a, dq_i);

  // read path and bus resolution
  always @* begin
    drive = !ce_n_i && !oe_n_i && we_n_i;
    rd = (hv_i || idm) ? id_byte(addr_i) : arr(addr_i);
    if (dq_oe_i) last = dq_i;
    else if (drive) last = rd;
  end
  assign bus_o = dq_oe_i ? dq_i : drive ? rd : ~last;
endmodule
`default_nettype wire

// ==== bench/tb_parallel_flash_command_interface.sv ====
// Purpose: self-checking bench for the flash command controller
// Assumes: flash model on the far side, sector 7 protected
// Notes:   each scenario is one task
`default_nettype none
module tb_parallel_flash_command_interface
  import pfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MFR  = 8'h07; // arbitrary value
  localparam logic [7:0] PART = 8'h8C; // arbitrary value
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  pfc_req_t req = '0;
  logic rdy, rv, pok, rerr, idm, ers, ce_n, oe_n, we_n, dq_oe, hv;
  logic [7:0] rdata, dq_o, bus;
  logic [18:0] fa;
  int err_total = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  pfc_ctrl dut_u (.REF_CLK_I(clk), .RST_I(rst), .REQ_VALID_I(req_valid), .REQ_I(req), .REQ_READY_O(rdy),
    .RSP_VALID_O(rv), .RSP_DATA_O(rdata), .RSP_PARITY_OK_O(pok), .RSP_ERR_O(rerr), .ID_MODE_O(idm),
    .ERASING_O(ers), .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n), .FLASH_ADDR_O(fa),
    .FLASH_DQ_O(dq_o), .FLASH_DQ_OE_O(dq_oe), .FLASH_DQ_I(bus), .FLASH_HV_O(hv));
  pfc_flash_model #(.MFR_CODE(MFR), .PART_CODE(PART), .PROT_MASK(8'h80)) flash_u (.ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(dq_o), .dq_oe_i(dq_oe), .hv_i(hv), .bus_o(bus));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait one cycle at a time, a hang ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 500) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic op(input pfc_op_t o, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1) tick(n);
    req = '{op: o, addr: a, data: d};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rv !== 1'b1) tick(n);
  endtask

  task automatic rd(input pfc_op_t o, input logic [18:0] a, input logic [7:0] exp);
    op(o, a, 8'h00);
    chk(rdata, exp);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_boot();
    rd(PFC_OP_READ, 19'h12345, 8'hFF);
    op(PFC_OP_ID_READ, 19'h00000, 8'h00);
    chk(rerr, 1'b1);
    chk(rdata, 8'h00);
    op(PFC_OP_SUSPEND, 19'h00000, 8'h00);
    chk(rerr, 1'b1);
  endtask

  task automatic t_prog();
    op(PFC_OP_PROGRAM, 19'h12345, 8'h5A);
    rd(PFC_OP_READ, 19'h12345, 8'h5A);
    op(PFC_OP_PROGRAM, 19'h70010, 8'h33);
    rd(PFC_OP_READ, 19'h70010, 8'hFF);
    op(PFC_OP_RESET1, 19'h4ABCD, 8'h00);
    rd(PFC_OP_READ, 19'h12345, 8'h5A);
  endtask

  task automatic t_ident();
    op(PFC_OP_IDENT, 19'h00000, 8'h00);
    chk(idm, 1'b1);
    rd(PFC_OP_ID_READ, 19'h00000, MFR);
    chk(pok, 1'b1);
    rd(PFC_OP_ID_READ, 19'h00001, PART);
    chk(pok, 1'b1);
    rd(PFC_OP_ID_READ, 19'h70002, 8'h01);
    rd(PFC_OP_ID_READ, 19'h00002, 8'h00);
    op(PFC_OP_RESET4, 19'h00000, 8'h00);
    chk(idm, 1'b0);
    rd(PFC_OP_READ, 19'h12345, 8'h5A);
  endtask

  task automatic t_hv();
    rd(PFC_OP_HV_READ, 19'h7FB81, PART);
    rd(PFC_OP_HV_READ, 19'h7FB80, MFR);
    rd(PFC_OP_HV_READ, 19'h70002, 8'h01);
  endtask

  task automatic t_erase();
    op(PFC_OP_SECT_ER, 19'h1F000, 8'h00);
    chk(ers, 1'b1);
    op(PFC_OP_SUSPEND, 19'h00000, 8'h00);
    chk(rerr, 1'b0);
    op(PFC_OP_RESUME, 19'h00000, 8'h00);
    chk(rerr, 1'b0);
    rd(PFC_OP_READ, 19'h12345, 8'hFF);
    op(PFC_OP_RESET1, 19'h00000, 8'h00);
    chk(ers, 1'b0);
    op(PFC_OP_PROGRAM, 19'h20000, 8'h77);
    op(PFC_OP_CHIP_ER, 19'h00000, 8'h00);
    rd(PFC_OP_READ, 19'h20000, 8'hFF);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_boot();
    t_prog();
    t_ident();
    t_hv();
    t_erase();
    end_sim();
  end
endmodule
`default_nettype wire
